// ===== mar_pkg.sv
// constants, types and state layout for the modbus analog register reader
package mar_pkg;
   localparam int MAR_NCH = 8;
   localparam int MAR_ARR_AW = 8;
   localparam logic [7:0] MAR_FC_HOLD = 8'h03;
   localparam logic [7:0] MAR_FC_INPUT = 8'h04;
   localparam logic [7:0] MAR_EXC_BIT = 8'h80;
   localparam logic [7:0] MAR_EXC_FUNC = 8'h01;
   localparam logic [7:0] MAR_EXC_ADDR = 8'h02;
   localparam logic [15:0] MAR_FLT_MAX_START = 16'h000e;
   localparam logic [15:0] MAR_CNT_MAX_START = 16'h0007;
   localparam logic [15:0] MAR_FLT_MAX_QTY = 16'h0008;
   localparam logic [15:0] MAR_CNT_MAX_QTY = 16'h0010;
   localparam logic [16:0] MAR_FLT_MAP = 17'h00010;
   localparam logic [16:0] MAR_CNT_MAP = 17'h00008;
   localparam logic MAR_FMT_FLOAT = 1'b0;
   localparam logic [5:0] MAR_IDX_FC = 6'h00;
   localparam logic [5:0] MAR_IDX_SHI = 6'h01;
   localparam logic [5:0] MAR_IDX_SLO = 6'h02;
   localparam logic [5:0] MAR_IDX_QHI = 6'h03;
   localparam logic [5:0] MAR_IDX_QLO = 6'h04;
   localparam logic [5:0] MAR_IDX_BC = 6'h01;
   localparam logic [5:0] MAR_IDX_DATA = 6'h02;

   typedef enum logic [2:0] {
      MAR_ST_RECV = 3'h1,
      MAR_ST_CHECK = 3'h2,
      MAR_ST_SEND = 3'h4
   } mar_state_e;

   typedef struct packed {
      logic [31:0] volts;
      logic [15:0] counts;
   } mar_chan_s;

   typedef struct packed {
      mar_state_e fsm;
      logic [5:0] idx;
      logic [7:0] fc;
      logic [15:0] start;
      logic [15:0] qty;
      logic fmt;
      logic swap;
      logic exc;
      logic [7:0] exc_code;
      logic [7:0] tx_byte;
      logic [5:0] m_idx;
      logic m_exc;
      logic [7:0] m_hi;
      logic [MAR_ARR_AW-1:0] m_ptr;
      logic [7:0] m_rcode;
      logic [7:0] m_xcode;
      logic m_we;
      logic [MAR_ARR_AW-1:0] m_waddr;
      logic [15:0] m_wdata;
   } mar_state_s;
endpackage

// ===== mar_reader.sv
// modbus read holding/input register responder with master-side response capture
`timescale 1ns/1ps
module mar_reader import mar_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic register_format_select,
   input wire logic function_map_swap,
   input wire mar_chan_s [MAR_NCH-1:0] ain,
   input wire mar_chan_s [MAR_NCH-1:0] aout,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic mrx_valid,
   input wire logic mrx_first,
   input wire logic [7:0] mrx_data,
   input wire logic [MAR_ARR_AW-1:0] raw_bus_send_command,
   output logic [7:0] response_code_query,
   output logic [7:0] exception_code_query,
   output logic arr_we,
   output logic [MAR_ARR_AW-1:0] arr_addr,
   output logic [15:0] arr_data
);
   mar_state_s st_reg;
   mar_state_s st_next;
   mar_chan_s [MAR_NCH-1:0] sel;
   logic [5:0] last_idx;
   logic tx_fire;
   logic [16:0] span;

   // code 3 reads inputs unless swapped; swap is the latched copy so data never
   // changes set in mid-response
   genvar g;
   generate
      for (g = 0; g < MAR_NCH; g++) begin : g_sel
         assign sel[g] = ((st_reg.fc == MAR_FC_HOLD) ^ st_reg.swap) ? ain[g] : aout[g];
      end
   endgenerate

   function automatic logic [7:0] resp_byte(input mar_state_s s, input logic [5:0] i);
      logic [5:0] j;
      logic [15:0] r;
      logic [15:0] w;
      j = i - MAR_IDX_DATA;
      r = s.start + 16'(j[5:1]);
      if (s.fmt == MAR_FMT_FLOAT) begin
         // high register of the float first
         w = r[0] ? sel[r[3:1]].volts[15:0] : sel[r[3:1]].volts[31:16];
      end else begin
         w = sel[r[2:0]].counts;
      end
      if (i == MAR_IDX_FC) begin
         resp_byte = s.exc ? (s.fc | MAR_EXC_BIT) : s.fc;
      end else if (i == MAR_IDX_BC) begin
         resp_byte = s.exc ? s.exc_code : {s.qty[6:0], 1'b0};
      end else begin
         resp_byte = j[0] ? w[7:0] : w[15:8];
      end
   endfunction

   assign last_idx = st_reg.exc ? MAR_IDX_BC : 6'(MAR_IDX_BC + {st_reg.qty[4:0], 1'b0});
   assign rx_ready = (st_reg.fsm == MAR_ST_RECV);
   assign tx_valid = (st_reg.fsm == MAR_ST_SEND);
   assign tx_last = tx_valid && (st_reg.idx == last_idx);
   assign tx_fire = tx_valid && tx_ready;
   assign tx_data = st_reg.tx_byte;
   assign span = {1'b0, st_reg.start} + {1'b0, st_reg.qty};
   assign response_code_query = st_reg.m_rcode;
   assign exception_code_query = st_reg.m_xcode;
   assign arr_we = st_reg.m_we;
   assign arr_addr = st_reg.m_waddr;
   assign arr_data = st_reg.m_wdata;

   always_comb begin
      st_next = st_reg;
      st_next.m_we = 1'b0;
      case (st_reg.fsm)
         MAR_ST_RECV: begin
            if (rx_valid) begin
               case (st_reg.idx)
                  MAR_IDX_FC: st_next.fc = rx_data;
                  MAR_IDX_SHI: st_next.start[15:8] = rx_data;
                  MAR_IDX_SLO: st_next.start[7:0] = rx_data;
                  MAR_IDX_QHI: st_next.qty[15:8] = rx_data;
                  default: st_next.qty[7:0] = rx_data;
               endcase
               st_next.idx = st_reg.idx + 6'h01;
               if (st_reg.idx == MAR_IDX_QLO) begin
                  st_next.fsm = MAR_ST_CHECK;
               end
            end
         end
         MAR_ST_CHECK: begin
            st_next.fmt = register_format_select;
            st_next.swap = function_map_swap;
            st_next.exc = 1'b1;
            st_next.exc_code = MAR_EXC_ADDR;
            if (st_reg.fc != MAR_FC_HOLD && st_reg.fc != MAR_FC_INPUT) begin
               st_next.exc_code = MAR_EXC_FUNC;
            end else if (register_format_select == MAR_FMT_FLOAT) begin
               st_next.exc = (st_reg.start > MAR_FLT_MAX_START) || (st_reg.qty == '0) ||
                  (st_reg.qty > MAR_FLT_MAX_QTY) || (span > MAR_FLT_MAP);
            end else begin
               st_next.exc = (st_reg.start > MAR_CNT_MAX_START) || (st_reg.qty == '0) ||
                  (st_reg.qty > MAR_CNT_MAX_QTY) || (span > MAR_CNT_MAP);
            end
            st_next.idx = MAR_IDX_FC;
            st_next.tx_byte = resp_byte(st_next, MAR_IDX_FC);
            st_next.fsm = MAR_ST_SEND;
         end
         MAR_ST_SEND: begin
            if (tx_fire) begin
               st_next.idx = st_reg.idx + 6'h01;
               st_next.tx_byte = resp_byte(st_reg, st_reg.idx + 6'h01);
               if (tx_last) begin
                  st_next.idx = MAR_IDX_FC;
                  st_next.fsm = MAR_ST_RECV;
               end
            end
         end
         default: st_next.fsm = MAR_ST_RECV;
      endcase
      // master side: a response frame starts at mrx_first, framing is resynced there
      if (mrx_valid) begin
         if (mrx_first) begin
            st_next.m_rcode = mrx_data;
            st_next.m_exc = mrx_data[7];
            st_next.m_ptr = raw_bus_send_command;
            st_next.m_idx = MAR_IDX_BC;
         end else if (st_reg.m_idx == MAR_IDX_BC) begin
            if (st_reg.m_exc) begin
               st_next.m_xcode = mrx_data;
            end
            st_next.m_idx = MAR_IDX_DATA;
         end else if (!st_reg.m_exc && st_reg.m_idx >= MAR_IDX_DATA) begin
            st_next.m_idx = st_reg.m_idx + 6'h01;
            if (st_reg.m_idx[0] == MAR_IDX_DATA[0]) begin
               st_next.m_hi = mrx_data;
            end else begin
               st_next.m_we = 1'b1;
               st_next.m_waddr = st_reg.m_ptr;
               st_next.m_wdata = {st_reg.m_hi, mrx_data};
               st_next.m_ptr = st_reg.m_ptr + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.fsm <= MAR_ST_RECV;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_fc_echo: assert property (tx_valid && st_reg.idx == MAR_IDX_FC && !st_reg.exc |->
      tx_data == st_reg.fc) else $error("function code not echoed");
   a_exc_code: assert property (tx_valid && st_reg.idx == MAR_IDX_FC && st_reg.exc |->
      tx_data[7] && tx_data[6:0] == st_reg.fc[6:0] ##0 tx_valid) else $error("bad exception code");
   a_byte_count: assert property (tx_valid && st_reg.idx == MAR_IDX_BC && !st_reg.exc |->
      tx_data == 8'(st_reg.qty * 2) && tx_data <= 8'h20) else $error("byte count wrong");
   a_frame_len: assert property (tx_last && !st_reg.exc |->
      st_reg.idx == 6'(2 * st_reg.qty + 1)) else $error("response length mismatch");
   // a bad function code takes precedence and answers with code 01, so only legal codes here
   a_float_start: assert property (st_reg.fsm == MAR_ST_CHECK && !register_format_select &&
      (st_reg.fc == MAR_FC_HOLD || st_reg.fc == MAR_FC_INPUT) &&
      st_reg.start > MAR_FLT_MAX_START |=> st_reg.exc && st_reg.exc_code == MAR_EXC_ADDR)
      else $error("float start not refused");
   a_count_start: assert property (st_reg.fsm == MAR_ST_CHECK && register_format_select &&
      st_reg.start > MAR_CNT_MAX_START |=> st_reg.exc) else $error("counts start not refused");
   a_float_qty: assert property (st_reg.fsm == MAR_ST_CHECK && !register_format_select &&
      st_reg.qty > MAR_FLT_MAX_QTY |=> st_reg.exc) else $error("float quantity not refused");
   a_mode_hold: assert property (st_reg.fsm == MAR_ST_SEND && $past(st_reg.fsm) == MAR_ST_SEND |->
      $stable(st_reg.fmt) && $stable(st_reg.swap)) else $error("format changed mid-response");
   a_float_msb: assert property (tx_valid && !st_reg.exc && !st_reg.fmt &&
      st_reg.idx == MAR_IDX_DATA &&
      st_reg.start[0] == 1'b0 |-> tx_data == sel[st_reg.start[3:1]].volts[31:24])
      else $error("float not high byte first");
   a_master_code: assert property (mrx_valid && mrx_first |=>
      response_code_query == $past(mrx_data)) else $error("response code not captured");
   a_master_store: assert property (mrx_valid && !mrx_first && !st_reg.m_exc &&
      st_reg.m_idx >= MAR_IDX_DATA && st_reg.m_idx[0] |=> arr_we && arr_data[7:0] == $past(mrx_data)
      && arr_addr == $past(st_reg.m_ptr)) else $error("register word not stored");

   c_float_read: cover property (tx_last && !st_reg.exc && !st_reg.fmt);
   c_count_read: cover property (tx_last && !st_reg.exc && st_reg.fmt);
   c_exception: cover property (tx_last && st_reg.exc);
   c_swap_read: cover property (tx_last && st_reg.swap && st_reg.fc == MAR_FC_HOLD);
endmodule

// ===== mar_master_model.sv
// modbus master model: sends requests and gathers the answers
`timescale 1ns/1ps
module mar_master_model (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [7:0] resp[$];
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // each byte is held until the responder takes it
   task automatic transact(input logic [39:0] req);
      logic done;
      resp.delete();
      for (int i = 4; i >= 0; i--) begin
         @(negedge clk_sys);
         rx_valid = 1'b1;
         rx_data = req[i*8 +: 8];
         @(posedge clk_sys);
         while (rx_ready !== 1'b1) @(posedge clk_sys);
      end
      done = 1'b0;
      while (!done) begin
         @(negedge clk_sys);
         rx_valid = 1'b0;
         // released line keeps toggling so a stale byte never looks valid
         rx_data = ~rx_data;
         tx_ready = slow ? ~tx_ready : 1'b1;
         @(posedge clk_sys);
         if (tx_valid === 1'b1 && tx_ready) begin
            resp.push_back(tx_data);
            done = tx_last === 1'b1;
         end
      end
      @(negedge clk_sys);
      tx_ready = 1'b0;
   endtask
endmodule

// ===== modbus_analog_register_reader_test.sv
// self-checking bench for the modbus analog register reader
`timescale 1ns/1ps
module modbus_analog_register_reader_test import mar_pkg::*;;
   logic clk_sys, reset, fmt, swap, slow, rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
   logic mrx_valid, mrx_first, arr_we;
   logic [7:0] rx_data, tx_data, mrx_data, base, rcode, xcode, arr_addr, xb[$];
   logic [15:0] arr_data;
   logic [23:0] wq[$];
   mar_chan_s [MAR_NCH-1:0] ain, aout;
   int n_mismatch = 0, checked = 0;
   // fmt, swap, fc, start, qty, expected code and byte count (exception code for refused requests)
   logic [57:0] rows[12] = '{{2'b10, 56'h03_0002_0004_0308}, {2'b10, 56'h04_0000_0008_0410},
      {2'b00, 56'h03_000e_0002_0304}, {2'b01, 56'h04_0002_0008_0410},
      {2'b00, 56'h04_0003_0003_0406}, {2'b11, 56'h03_0007_0001_0302},
      {2'b00, 56'h03_000f_0001_8302}, {2'b10, 56'h04_0008_0001_8402},
      {2'b00, 56'h03_0000_0009_8302}, {2'b10, 56'h03_0000_0000_8302},
      {2'b10, 56'h04_0004_0005_8402}, {2'b00, 56'h06_0000_0001_8601}};
   mar_reader mar_reader_i (.clk_sys(clk_sys), .reset(reset), .register_format_select(fmt),
      .function_map_swap(swap), .ain(ain), .aout(aout), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .mrx_valid(mrx_valid), .mrx_first(mrx_first),
      .mrx_data(mrx_data), .raw_bus_send_command(base), .response_code_query(rcode),
      .exception_code_query(xcode), .arr_we(arr_we), .arr_addr(arr_addr), .arr_data(arr_data));
   mar_master_model mar_master_model_i (.clk_sys(clk_sys), .slow(slow), .rx_ready(rx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready));
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_resp(input logic [57:0] row);
      mar_chan_s c;
      logic [15:0] w;
      xb.delete();
      for (int r = row[47:32]; r < row[47:32] + row[31:16] && !row[15]; r++) begin
         c = ((row[55:48] == MAR_FC_INPUT) ^ row[56]) ? aout[row[57] ? r : r / 2]
            : ain[row[57] ? r : r / 2];
         w = row[57] ? c.counts : (r % 2 ? c.volts[15:0] : c.volts[31:16]);
         xb.push_back(w[15:8]);
         xb.push_back(w[7:0]);
      end
      cmp_byte(8'(mar_master_model_i.resp.size()), 8'(xb.size() + 2));
      cmp_byte(mar_master_model_i.resp[0], row[15:8]);
      cmp_byte(mar_master_model_i.resp[1], row[7:0]);
      foreach (xb[i]) cmp_byte(mar_master_model_i.resp[i + 2], xb[i]);
   endtask
   task automatic feed(input logic [7:0] b, input logic first);
      @(negedge clk_sys);
      mrx_valid = 1'b1;
      mrx_first = first;
      mrx_data = b;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (arr_we === 1'b1) wq.push_back({arr_addr, arr_data});
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      close_out();
   end
   initial begin
      {reset, fmt, swap, slow, mrx_valid, mrx_first, mrx_data, base} = {6'h20, 8'h00, 8'h10};
      for (int i = 0; i < MAR_NCH; i++) begin
         ain[i] = {8'h3f, 8'(i), 16'h5a00 + 16'(i), 16'h1000 + 16'(i)};
         aout[i] = {8'h40, 8'(i), 16'ha500 + 16'(i), 16'h2000 + 16'(i)};
      end
      repeat (4) @(negedge clk_sys);
      cmp_byte({rx_ready, tx_valid, tx_last, arr_we, 4'h0}, 8'h80);
      cmp_word({rcode, xcode, tx_data}, 24'h000000);
      reset = 1'b0;
      $display("reset test done");
      foreach (rows[k]) begin
         {fmt, swap} = rows[k][57:56];
         mar_master_model_i.transact(rows[k][55:16]);
         check_resp(rows[k]);
         $display("row %0d done", k);
      end
      {fmt, swap, slow} = 3'b101;
      fork
         mar_master_model_i.transact({8'h03, 16'h0001, 16'h0004});
         begin
            repeat (9) @(negedge clk_sys);
            {fmt, swap} = 2'b01;
         end
      join
      check_resp({2'b10, 56'h03_0001_0004_0308});
      $display("stall and held mode test done");
      feed(8'h03, 1'b1);
      feed(8'h04, 1'b0);
      feed(8'h12, 1'b0);
      feed(8'h34, 1'b0);
      feed(8'hab, 1'b0);
      feed(8'hcd, 1'b0);
      feed(8'h84, 1'b1);
      cmp_byte(rcode, 8'h03);
      feed(8'h02, 1'b0);
      feed(8'h55, 1'b0);
      feed(8'h66, 1'b0);
      @(negedge clk_sys);
      mrx_valid = 1'b0;
      repeat (2) @(negedge clk_sys);
      cmp_word({rcode, 8'h00, xcode}, 24'h840002);
      cmp_byte(8'(wq.size()), 8'h02);
      cmp_word(wq[0], 24'h101234);
      cmp_word(wq[1], 24'h11abcd);
      $display("master capture test done");
      // reset in mid-run must clear the captured codes and leave the responder usable
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      cmp_word({rcode, xcode, 7'h00, rx_ready}, 24'h000001);
      reset = 1'b0;
      {fmt, swap} = rows[0][57:56];
      mar_master_model_i.transact(rows[0][55:16]);
      check_resp(rows[0]);
      $display("mid-run reset test done");
      close_out();
   end
endmodule
